/* File: hw/spimf_pkg.sv */
// Constants shared by the SPI master block
package spimf_pkg;
  localparam logic [7:0] SPIMF_ADDR_CONFIG0 = 8'h00_fc;
  localparam logic [7:0] SPIMF_ADDR_IRQ_MASKS = 8'h00_fd;
  localparam logic [7:0] SPIMF_ADDR_STATUS = 8'h00_fe;
  localparam logic [7:0] SPIMF_ADDR_DATA = 8'h00_ff;
  localparam logic [6:0] SPIMF_CONFIG0_RESET = 7'h20;
  localparam logic [3:0] SPIMF_IRQ_MASKS_RESET = 4'h0f;
  localparam logic [3:0] SPIMF_STATUS_RESET = 4'h03;
  localparam int SPIMF_BIT_ON = 0;
  localparam int SPIMF_BIT_PHASE = 1;
  localparam int SPIMF_BIT_POL = 2;
  localparam int SPIMF_BIT_LSB = 3;
  localparam int SPIMF_DIV_LO = 4;
  localparam int SPIMF_DIV_HI = 6;
  localparam int SPIMF_ST_TX_SPACE = 0;
  localparam int SPIMF_ST_TX_EMPTY = 1;
  localparam int SPIMF_ST_RX_AVAIL = 2;
  localparam int SPIMF_ST_RX_FULL = 3;
  localparam logic [2:0] SPIMF_DIV_MAX_CODE = 3'h5;
  localparam int SPIMF_FIFO_DEPTH = 2;
  localparam int SPIMF_BYTE_BITS = 8;
endpackage

/* File: hw/spimf_fifo.sv */
// Small byte FIFO with registered read data
`timescale 1ns/1ns
module spimf_fifo
  import spimf_pkg::*;
#(
  parameter int WIDTH = SPIMF_BYTE_BITS,
  parameter int DEPTH = SPIMF_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [WIDTH-1:0] rd_reg, rd_next;
  logic do_push, do_pop;

  // Head word kept in a register so readers see a stable byte
  always_comb begin
    do_pop = pop_i && (cnt_reg != '0);
    do_push = push_i && ((cnt_reg != CW'(DEPTH)) || do_pop);
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (do_push) begin
      mem_next[wp_reg] = wdata_i;
      wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : AW'(wp_reg + 1'b1);
    end
    if (do_pop) begin
      rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : AW'(rp_reg + 1'b1);
    end
    cnt_next = CW'(cnt_reg + CW'(do_push) - CW'(do_pop));
    rd_next = mem_next[rp_next];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rd_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
    end
  end

  assign rdata_o = rd_reg;
  assign count_o = cnt_reg;
endmodule // spimf_fifo

/* File: hw/spimf_clkdiv.sv */
// Serial clock rate divider producing half-period enable pulses
`timescale 1ns/1ns
module spimf_clkdiv
  import spimf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [2:0] code_i,
  output logic tick_o
);
  logic [4:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  logic [2:0] code_eff;
  logic [4:0] limit;

  // Half period is divisor/2 cycles; codes above five fold to divide-by-64
  always_comb begin
    code_eff = (code_i > SPIMF_DIV_MAX_CODE) ? SPIMF_DIV_MAX_CODE : code_i;
    limit = 5'((6'h01 << code_eff) - 6'h01);
    cnt_next = '0;
    tick_next = 1'b0;
    if (run_i) begin
      if (cnt_reg >= limit) begin
        tick_next = 1'b1;
      end else begin
        cnt_next = 5'(cnt_reg + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule // spimf_clkdiv

/* File: hw/spimf_top.sv */
// SPI master with register port, two-byte FIFOs and serial engine
`timescale 1ns/1ns
module spimf_top
  import spimf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o,
  output logic serial_clock_out_o,
  output logic serial_data_out_o,
  input wire logic serial_data_in_i
);
  typedef enum logic [2:0] {
    SPIMF_IDLE = 3'b001,
    SPIMF_LOAD = 3'b010,
    SPIMF_SHIFT = 3'b100
  } spimf_state_e;

  localparam logic [3:0] BIT_LAST = 4'(SPIMF_BYTE_BITS - 1);
  localparam int CW = $clog2(SPIMF_FIFO_DEPTH + 1);

  logic [6:0] master_config0_reg, master_config0_next;
  logic [3:0] master_irq_masks_reg, master_irq_masks_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  spimf_state_e state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_reg, bit_next;
  logic lead_reg, lead_next;
  logic sck_reg, sck_next;
  logic mosi_reg, mosi_next;
  logic [7:0] rx_byte_reg, rx_byte_next;
  logic sync1_reg, sync2_reg, sync3_reg, din_reg, din_next;
  logic tx_pop, rx_push, rx_pop, tx_push;
  logic [7:0] tx_head, rx_head;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic tick;
  logic master_on, sclk_idle_level, sample_edge_sel, lsb_first_sel;
  logic [2:0] sclk_divider_sel;
  logic [3:0] status;
  logic sample_now;
  logic [2:0] bit_idx;

  assign master_on = master_config0_reg[SPIMF_BIT_ON];
  assign sample_edge_sel = master_config0_reg[SPIMF_BIT_PHASE];
  assign sclk_idle_level = master_config0_reg[SPIMF_BIT_POL];
  assign lsb_first_sel = master_config0_reg[SPIMF_BIT_LSB];
  assign sclk_divider_sel = master_config0_reg[SPIMF_DIV_HI:SPIMF_DIV_LO];

  // Live status from FIFO levels, nothing sticky
  always_comb begin
    status = '0;
    status[SPIMF_ST_RX_FULL] = (rx_cnt == CW'(SPIMF_FIFO_DEPTH));
    status[SPIMF_ST_RX_AVAIL] = (rx_cnt != '0);
    status[SPIMF_ST_TX_EMPTY] = (tx_cnt == '0);
    status[SPIMF_ST_TX_SPACE] = (tx_cnt != CW'(SPIMF_FIFO_DEPTH));
  end

  assign tx_push = reg_wr_i && (reg_addr_i == SPIMF_ADDR_DATA);
  assign rx_pop = reg_rd_i && (reg_addr_i == SPIMF_ADDR_DATA);

  spimf_fifo #(
    .WIDTH(SPIMF_BYTE_BITS),
    .DEPTH(SPIMF_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .push_i(tx_push),
    .wdata_i(reg_wdata_i),
    .pop_i(tx_pop),
    .rdata_o(tx_head),
    .count_o(tx_cnt)
  );

  spimf_fifo #(
    .WIDTH(SPIMF_BYTE_BITS),
    .DEPTH(SPIMF_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .push_i(rx_push),
    // Next value so a last bit sampled on the final edge is kept
    .wdata_i(rx_byte_next),
    .pop_i(rx_pop),
    .rdata_o(rx_head),
    .count_o(rx_cnt)
  );

  spimf_clkdiv u_clkdiv (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(master_on && (state_reg == SPIMF_SHIFT)),
    .code_i(sclk_divider_sel),
    .tick_o(tick)
  );

  // Register port and interrupt
  always_comb begin
    master_config0_next = master_config0_reg;
    master_irq_masks_next = master_irq_masks_reg;
    rdata_next = rdata_reg;
    if (reg_wr_i && (reg_addr_i == SPIMF_ADDR_CONFIG0)) begin
      master_config0_next = reg_wdata_i[6:0];
    end
    if (reg_wr_i && (reg_addr_i == SPIMF_ADDR_IRQ_MASKS)) begin
      master_irq_masks_next = reg_wdata_i[3:0];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        SPIMF_ADDR_CONFIG0: rdata_next = {1'b0, master_config0_reg};
        SPIMF_ADDR_IRQ_MASKS: rdata_next = {4'h0, master_irq_masks_reg};
        SPIMF_ADDR_STATUS: rdata_next = {4'h0, status};
        SPIMF_ADDR_DATA: rdata_next = rx_head;
        default: rdata_next = 8'h00;
      endcase
    end
    irq_next = |(status & ~master_irq_masks_reg);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      master_config0_reg <= SPIMF_CONFIG0_RESET;
      master_irq_masks_reg <= SPIMF_IRQ_MASKS_RESET;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      master_config0_reg <= master_config0_next;
      master_irq_masks_reg <= master_irq_masks_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // Data-in pin synchroniser; first stage read only by the second
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      din_reg <= 1'b0;
    end else begin
      sync1_reg <= serial_data_in_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      din_reg <= din_next;
    end
  end

  always_comb begin
    din_next = (sync2_reg == sync3_reg) ? sync3_reg : din_reg;
  end

  // Serial engine; no slave select is made here
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    lead_next = lead_reg;
    sck_next = sck_reg;
    mosi_next = mosi_reg;
    rx_byte_next = rx_byte_reg;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    bit_idx = lsb_first_sel ? bit_reg[2:0] : 3'(BIT_LAST - bit_reg);
    sample_now = lead_reg ? !sample_edge_sel : sample_edge_sel;
    unique case (state_reg)
      SPIMF_IDLE: begin
        sck_next = sclk_idle_level;
        // Deferring on a full receive FIFO keeps every received byte
        if (master_on && (tx_cnt != '0) && (rx_cnt != CW'(SPIMF_FIFO_DEPTH))) begin
          state_next = SPIMF_LOAD;
        end
      end
      SPIMF_LOAD: begin
        shift_next = tx_head;
        tx_pop = 1'b1;
        bit_next = '0;
        lead_next = 1'b1;
        rx_byte_next = '0;
        // Phase 0 presents the first bit before the leading edge
        mosi_next = lsb_first_sel ? tx_head[0] : tx_head[SPIMF_BYTE_BITS-1];
        state_next = SPIMF_SHIFT;
      end
      SPIMF_SHIFT: begin
        if (!master_on) begin
          // Disable aborts the byte; clock parks at idle
          sck_next = sclk_idle_level;
          state_next = SPIMF_IDLE;
        end else if (tick) begin
          sck_next = !sck_reg;
          lead_next = !lead_reg;
          if (sample_now) begin
            // Filtered value, one cycle sooner than din_reg, fits a four-cycle half period
            rx_byte_next[bit_idx] = din_next;
          end
          if (!lead_reg) begin
            bit_next = 4'(bit_reg + 4'h1);
          end
          if (!lead_reg && (bit_reg == BIT_LAST)) begin
            state_next = SPIMF_IDLE;
            rx_push = 1'b1;
            sck_next = sclk_idle_level;
          end else if (!sample_now) begin
            // Shift edge: next bit; phase 1 shifts its first bit on the leading edge
            if (lead_reg) begin
              mosi_next = shift_reg[bit_idx];
            end else begin
              mosi_next = lsb_first_sel ? shift_reg[3'(bit_reg + 4'h1)]
                                        : shift_reg[3'(BIT_LAST - bit_reg - 4'h1)];
            end
          end
        end
      end
      default: state_next = SPIMF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= SPIMF_IDLE;
      shift_reg <= '0;
      bit_reg <= '0;
      lead_reg <= 1'b1;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      rx_byte_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      lead_reg <= lead_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      rx_byte_reg <= rx_byte_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign serial_clock_out_o = sck_reg;
  assign serial_data_out_o = mosi_reg;
endmodule // spimf_top

/* File: tb/spimf_props.sv */
// Port checker for the SPI master
`timescale 1ns/1ns
module spimf_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic serial_clock_out_o,
  input wire logic serial_data_out_o,
  input wire logic serial_data_in_i
);
  logic [6:0] cfg_reg, cfg_next;
  logic [3:0] msk_reg, msk_next;
  logic [2:0] q_reg, q_next;
  wire rs = reg_rd_i && reg_addr_i == 8'hfe;
  always_comb begin
    cfg_next = cfg_reg;
    msk_next = msk_reg;
    q_next = (q_reg == 3'h7) ? q_reg : q_reg + 3'h1;
    if (reg_wr_i && reg_addr_i == 8'hfc) begin
      cfg_next = reg_wdata_i[6:0];
      q_next = 3'h0;
    end
    if (reg_wr_i && reg_addr_i == 8'hfd) msk_next = reg_wdata_i[3:0];
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_reg <= 7'h20;
      msk_reg <= 4'hf;
      q_reg <= 3'h0;
    end else begin
      cfg_reg <= cfg_next;
      msk_reg <= msk_next;
      q_reg <= q_next;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_CFG_READ: assert property (reg_rd_i && reg_addr_i == 8'hfc |=> reg_rdata_o == {1'b0, $past(cfg_reg)})
    else $error("config readback wrong");
  AST_MASK_READ: assert property (reg_rd_i && reg_addr_i == 8'hfd |=> reg_rdata_o == {4'h0, $past(msk_reg)})
    else $error("mask readback wrong");
  AST_RX_FLAGS: assert property (rs |=> reg_rdata_o[7:4] == 4'h0 && (reg_rdata_o[3] -> reg_rdata_o[2]))
    else $error("rx flags inconsistent");
  AST_TX_FLAGS: assert property (rs |=> !(reg_rdata_o[1] && !reg_rdata_o[0]))
    else $error("tx flags inconsistent");
  AST_ALL_MASKED: assert property (msk_reg == 4'hf && $stable(msk_reg) |-> !irq_o)
    else $error("irq while all masked");
  // Settle time covers an abort in mid-byte
  AST_IDLE_OFF: assert property (!cfg_reg[0] && q_reg == 3'h7 |-> serial_clock_out_o == cfg_reg[2] && $stable(serial_data_out_o))
    else $error("serial lines move while off");
  AST_HALF_MIN: assert property (cfg_reg[0] && cfg_reg[6:4] != 3'h0 && $changed(serial_clock_out_o) |=> $stable(serial_clock_out_o))
    else $error("serial clock half period too short");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  cover property (rs ##1 reg_rdata_o[3]);
  cover property ($rose(irq_o));
  cover property (cfg_reg[2] && $fell(serial_clock_out_o));
endmodule // spimf_props
bind spimf_top spimf_props spimf_props_i (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .irq_o, .serial_clock_out_o, .serial_data_out_o, .serial_data_in_i);

/* File: tb/spimf_slave.sv */
// Behavioural SPI slave, always selected, counting up its reply
`timescale 1ns/1ns
module spimf_slave (
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  int n;
  initial miso_o = 1'b0;
  function automatic logic pick(input int i);
    return lsb_i ? sh[i] : sh[7-i];
  endfunction
  always @(posedge load_i) begin
    sh = tx_i;
    n = 0;
    miso_o = pick(0);
  end
  // Sample on one edge, change only on the other
  always @(sclk_i) begin
    if ((sclk_i != cpol_i) ^ cpha_i) begin
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      n++;
    end else begin
      if (n == 8) begin
        sh = sh + 8'h01;
        n = 0;
      end
      miso_o = pick(n);
    end
  end
endmodule // spimf_slave

/* File: tb/spimf_top_test.sv */
// Self-checking bench for the SPI master
`timescale 1ns/1ns
module spimf_top_test;
  logic clk = 0, rst_n = 0, we = 0, re = 0, ld = 0, pol = 0, pha = 0, lsb = 0;
  logic [7:0] addr = 0, wd = 0, stx = 0;
  logic [7:0] rdat, srx;
  logic irq, sclk, mosi, miso;
  int err_total = 0, total_checks = 0;
  always #20 clk = ~clk;
  spimf_top spimf_top_i (.clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(we), .reg_rd_i(re),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .irq_o(irq), .serial_clock_out_o(sclk), .serial_data_out_o(mosi),
    .serial_data_in_i(miso));
  spimf_slave spimf_slave_i (.sclk_i(sclk), .mosi_i(mosi), .cpol_i(pol), .cpha_i(pha), .lsb_i(lsb),
    .load_i(ld), .tx_i(stx), .miso_o(miso), .rx_o(srx));
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    d = rdat;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task wait_st(input int b);
    logic [7:0] v;
    for (int i = 0; i < 500; i++) begin
      rd(8'hfe, v);
      if (v[b] === 1'b1) return;
    end
  endtask
  task load(input logic [3:0] m, input logic [7:0] s);
    {lsb, pol, pha} = m[2:0];
    stx = s;
    @(negedge clk);
    ld = 1'b1;
    @(negedge clk);
    ld = 1'b0;
  endtask
  task t_reset;
    rc(8'hfc, 8'h20);
    rc(8'hfd, 8'h0f);
    rc(8'hfe, 8'h03);
    rc(8'hff, 8'h00);
    rc(8'h10, 8'h00);
    wr(8'hfe, 8'h00);
    rc(8'hfe, 8'h03);
  endtask
  task t_modes;
    logic [7:0] d;
    for (int m = 0; m < 8; m++) begin
      d = 8'h1d ^ m[7:0];
      wr(8'hfc, {4'h2, m[2:0], 1'b1});
      load(m[3:0], ~d);
      wr(8'hff, d);
      wait_st(2);
      rc(8'hff, ~d);
      chk(srx, d);
      chk({7'h0, sclk}, {7'h0, m[1]});
    end
  endtask
  task t_fifo;
    wr(8'hfc, 8'h24);
    load(4'h2, 8'h40);
    wr(8'hff, 8'h11);
    rc(8'hfe, 8'h01);
    wr(8'hff, 8'h22);
    rc(8'hfe, 8'h00);
    wr(8'hff, 8'h33);
    wr(8'hfd, 8'h07);
    wr(8'hfc, 8'h25);
    wait_st(3);
    rc(8'hfe, 8'h0f);
    chk({7'h0, irq}, 8'h01);
    wr(8'hff, 8'h44);
    // Long enough for a whole byte had it not been held back
    repeat (120) @(negedge clk);
    rc(8'hfe, 8'h0d);
    rc(8'hff, 8'h40);
    wait_st(3);
    rc(8'hff, 8'h41);
    rc(8'hff, 8'h42);
    rc(8'hfe, 8'h03);
    chk(srx, 8'h44);
  endtask
  task t_irq;
    wr(8'hfd, 8'h0e);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(8'hfd, 8'h0d);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(8'hfc, 8'h24);
    wr(8'hff, 8'h55);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(8'hfd, 8'h0f);
    wr(8'hfc, 8'h51);
    repeat (40) @(negedge clk);
    wr(8'hfc, 8'h50);
    repeat (10) @(negedge clk);
    chk({7'h0, sclk}, 8'h00);
    rc(8'hfe, 8'h03);
  endtask
  task gap(input logic [2:0] c, output int g);
    logic [7:0] v;
    wr(8'hfc, {1'b0, c, 4'h1});
    wr(8'hff, 8'h3c);
    g = 0;
    for (int i = 0; i < 100 && sclk !== 1'b1; i++) @(negedge clk);
    while (sclk === 1'b1 && g < 100) begin
      @(negedge clk);
      g++;
    end
    wait_st(2);
    rd(8'hff, v);
  endtask
  task t_div;
    int g3, g;
    gap(3'h3, g3);
    for (int c = 4; c < 8; c++) begin
      gap(c[2:0], g);
      chk(g[7:0], g3[7:0] << (c > 5 ? 2 : c - 3));
    end
  endtask
  initial begin
    #(40 * 60000);
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_modes;
    t_fifo;
    t_irq;
    t_div;
    report_and_stop;
  end
endmodule // spimf_top_test
